// [bench/cpu_register_file_tb.sv]
// Self-checking testbench for the CPU register file.
`timescale 1ns/1ps
`default_nettype none

module cpu_register_file_tb
    import crf_pkg::*;
();
    localparam logic [15:0] VEC_WORD = 16'hc3a5;

    // =============================================================
    // Design connections
    logic          ref_clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          slow = 1'b0;
    crf_pc_op_t    pc_op;
    crf_sp_op_t    sp_op;
    crf_hx_op_t    hx_op;
    crf_addr_sel_t addr_sel;
    logic          acc_we, flags_we, irq_stacked, mem_rvalid, vec_rd, cpu_run;
    logic [7:0]    branch_off, stack_adjust_immediate, acc_wdata, flags_wdata, direct_off;
    logic [7:0]    mem_rdata, accumulator, arith_operand_a, condition_flags;
    logic [15:0]   pc_load_addr, sp_load_val, hx_wdata, index_off, ext_addr, mem_addr;
    logic [15:0]   branch_target, indexed_addr, index_pair, stack_pointer, program_counter;
    int            err_count = 0;
    int            comparisons = 0;
    int            cycles = 0;

    crf_regfile dut_u (.*);
    crf_mem_model #(.vec_word(VEC_WORD)) mem_u (.ref_clk(ref_clk), .rst_n(rst_n),
        .slow(slow), .mem_addr(mem_addr), .vec_rd(vec_rd), .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid));

    // Clock, 20 ns period
    always #10 ref_clk = ~ref_clk;

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            finish_test();
        end
    end

    // =============================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Inputs always change 1 ns after the edge
    task automatic run(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : run

    task automatic idle();
        pc_op = CRF_PC_HOLD;
        sp_op = CRF_SP_HOLD;
        hx_op = CRF_HX_HOLD;
        acc_we = 1'b0;
        flags_we = 1'b0;
        irq_stacked = 1'b0;
    endtask : idle

    task automatic pc_do(input crf_pc_op_t op, input logic [15:0] val, input logic [15:0] exp);
        pc_op = op;
        pc_load_addr = val;
        branch_off = val[7:0];
        run(1);
        chk(program_counter, exp);
    endtask : pc_do

    task automatic sp_do(input crf_sp_op_t op, input logic [15:0] val, input logic [15:0] exp);
        sp_op = op;
        sp_load_val = val;
        stack_adjust_immediate = val[7:0];
        run(1);
        chk(stack_pointer, exp);
    endtask : sp_do

    task automatic hx_do(input crf_hx_op_t op, input logic [15:0] val, input logic [15:0] exp);
        hx_op = op;
        hx_wdata = val;
        run(1);
        chk(index_pair, exp);
    endtask : hx_do

    // =============================================================
    // Scenarios
    task automatic t_boot(input logic slow_sel);
        slow = slow_sel;
        rst_n = 1'b0;
        run(20);
        rst_n = 1'b1;
        chk({15'h0, vec_rd}, 16'h0001);
        chk(mem_addr, 16'hfffe);
        for (int i = 0; i < 12 && cpu_run !== 1'b1; i++) begin
            run(1);
        end
        chk({15'h0, cpu_run}, 16'h0001);
        chk(program_counter, VEC_WORD);
        chk(stack_pointer, 16'h00ff);
        chk({8'h00, index_pair[15:8]}, 16'h0000);
    endtask : t_boot

    task automatic t_acc();
        acc_we = 1'b1;
        acc_wdata = 8'h3c;
        run(1);
        acc_wdata = 8'hc3;
        chk({accumulator, arith_operand_a}, 16'h3c3c);
        run(1);
        acc_we = 1'b0;
        chk({accumulator, arith_operand_a}, 16'hc3c3);
    endtask : t_acc

    task automatic t_pc();
        pc_do(CRF_PC_JUMP, 16'hffff, 16'hffff);
        pc_do(CRF_PC_INC, 16'h0000, 16'h0000);
        pc_do(CRF_PC_INC, 16'h0000, 16'h0001);
        pc_do(CRF_PC_HOLD, 16'h0080, 16'h0001);
        chk(branch_target, 16'hff81);
        pc_do(CRF_PC_BRANCH, 16'h0080, 16'hff81);
        pc_do(CRF_PC_BRANCH, 16'h007f, 16'h0000);
        idle();
    endtask : t_pc

    task automatic t_sp();
        sp_do(CRF_SP_PUSH, 16'h0000, 16'h00fe);
        sp_do(CRF_SP_PULL, 16'h0000, 16'h00ff);
        sp_do(CRF_SP_LOAD, 16'h0000, 16'h0000);
        sp_do(CRF_SP_PUSH, 16'h0000, 16'hffff);
        sp_do(CRF_SP_ADJ, 16'h0080, 16'hff7f);
        sp_do(CRF_SP_ADJ, 16'h007f, 16'hfffe);
        sp_do(CRF_SP_ADJ, 16'h0002, 16'h0000);
        sp_do(CRF_SP_LOAD, 16'h1234, 16'h1234);
        sp_do(CRF_SP_LOWRST, 16'h0000, 16'h12ff);
        idle();
    endtask : t_sp

    task automatic t_hx();
        hx_do(CRF_HX_LOAD, 16'h12ff, 16'h12ff);
        hx_do(CRF_HX_INC_LOW, 16'h0000, 16'h1200);
        hx_do(CRF_HX_DEC_LOW, 16'h0000, 16'h12ff);
        hx_do(CRF_HX_INC, 16'h0000, 16'h1300);
        hx_do(CRF_HX_LOAD_HI, 16'hab55, 16'hab00);
        hx_do(CRF_HX_LOAD_LOW, 16'h5577, 16'hab77);
        hx_do(CRF_HX_LOAD, 16'hffff, 16'hffff);
        hx_do(CRF_HX_INC, 16'h0000, 16'h0000);
        hx_do(CRF_HX_DEC_LOW, 16'h0000, 16'h00ff);
        idle();
        index_off = 16'hff10;
        addr_sel = CRF_AS_INDEX;
        run(1);
        chk(indexed_addr, 16'h000f);
        chk(mem_addr, 16'h000f);
        addr_sel = CRF_AS_DIRECT;
        direct_off = 8'hab;
        run(1);
        chk(mem_addr, 16'h00ab);
        addr_sel = CRF_AS_EXT;
        ext_addr = 16'hbeef;
        run(1);
        chk(mem_addr, 16'hbeef);
        addr_sel = CRF_AS_STACK;
        run(1);
        chk(mem_addr, 16'h12ff);
        addr_sel = CRF_AS_PC;
        run(1);
        chk(mem_addr, 16'h0000);
    endtask : t_hx

    task automatic t_flags();
        flags_we = 1'b1;
        flags_wdata = 8'h00;
        run(1);
        chk({8'h00, condition_flags}, 16'h0060);
        flags_wdata = 8'hff;
        run(1);
        chk({8'h00, condition_flags}, 16'h00ff);
        flags_wdata = 8'h00;
        irq_stacked = 1'b1;
        run(1);
        chk({8'h00, condition_flags}, 16'h0068);
        idle();
    endtask : t_flags

    // Mid-run reset, slow vector
    task automatic t_keep();
        acc_we = 1'b1;
        acc_wdata = 8'h5a;
        hx_op = CRF_HX_LOAD;
        hx_wdata = 16'h1234;
        run(1);
        idle();
        t_boot(1'b1);
        chk({8'h00, accumulator}, 16'h005a);
        chk(index_pair, 16'h0034);
    endtask : t_keep

    task automatic finish_test();
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // =============================================================
    // Main sequence
    initial begin
        idle();
        {branch_off, stack_adjust_immediate, acc_wdata, flags_wdata, direct_off} = 40'h0;
        {pc_load_addr, sp_load_val, hx_wdata, index_off, ext_addr} = 80'h0;
        addr_sel = CRF_AS_PC;
        t_boot(1'b0);
        t_acc();
        t_pc();
        t_sp();
        t_hx();
        t_flags();
        t_keep();
        finish_test();
    end
endmodule : cpu_register_file_tb

`default_nettype wire

// [bench/crf_mem_model.sv]
// Memory side model that answers the reset vector fetch.
`timescale 1ns/1ps
`default_nettype none

module crf_mem_model #(
    parameter logic [15:0] vec_word = 16'h4000
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        slow,
    input  wire logic [15:0] mem_addr,
    input  wire logic        vec_rd,
    output logic [7:0]       mem_rdata,
    output logic             mem_rvalid
);
    logic [1:0] wait_q;

    // =============================================================
    // Vector read responder
    // One valid pulse per byte, after zero or three idle cycles; the data
    // flips on the edge that ends each valid pulse and while vec_rd is low, so a stale byte is never taken as good
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !vec_rd || mem_rvalid) begin
            wait_q     <= 2'h0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= rst_n ? ~mem_rdata : 8'h5a;
        end else if (wait_q == (slow ? 2'h3 : 2'h0)) begin
            mem_rvalid <= 1'b1;
            mem_rdata  <= mem_addr[0] ? vec_word[7:0] : vec_word[15:8];
        end else begin
            wait_q <= wait_q + 2'h1;
        end
    end
endmodule : crf_mem_model

`default_nettype wire

// [bench/crf_regfile_assertions.sv]
// Port-level assertions for the CPU register file.
`timescale 1ns/1ps
`default_nettype none

module crf_regfile_assertions
    import crf_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire crf_pc_op_t  pc_op,
    input wire logic [15:0] pc_load_addr,
    input wire crf_sp_op_t  sp_op,
    input wire logic [7:0]  stack_adjust_immediate,
    input wire crf_hx_op_t  hx_op,
    input wire logic        acc_we,
    input wire logic [7:0]  acc_wdata,
    input wire logic        irq_stacked,
    input wire logic [7:0]  mem_rdata,
    input wire logic        mem_rvalid,
    input wire logic [15:0] mem_addr,
    input wire logic        vec_rd,
    input wire logic        cpu_run,
    input wire logic [7:0]  branch_off,
    input wire logic [7:0]  accumulator,
    input wire logic [7:0]  arith_operand_a,
    input wire logic [15:0] index_pair,
    input wire logic [15:0] stack_pointer,
    input wire logic [15:0] program_counter,
    input wire logic [7:0]  condition_flags
);
    // =============================================================
    // Shared clock and reset
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // =============================================================
    // Vector fetch
    a_reset_state: assert property (
        $rose(rst_n) |-> stack_pointer == 16'h00ff && index_pair[15:8] == 8'h00
        && vec_rd && mem_addr == 16'hfffe) else $error("bad state after reset");
    a_vec_high: assert property (
        vec_rd && mem_rvalid && mem_addr == 16'hfffe |=> mem_addr == 16'hffff
        && program_counter[15:8] == $past(mem_rdata)) else $error("bad vector high");
    a_vec_low: assert property (
        vec_rd && mem_rvalid && mem_addr == 16'hffff |=> cpu_run && !vec_rd
        && program_counter[7:0] == $past(mem_rdata)) else $error("bad vector low");

    // =============================================================
    // Register updates
    a_acc_write: assert property (
        cpu_run && acc_we |=> accumulator == $past(acc_wdata)
        && arith_operand_a == accumulator) else $error("bad accumulator");
    a_pc_step: assert property (
        cpu_run && pc_op == CRF_PC_INC |=> program_counter == $past(program_counter) + 16'h0001)
        else $error("bad pc increment");
    a_pc_jump: assert property (
        cpu_run && pc_op == CRF_PC_JUMP |=> program_counter == $past(pc_load_addr))
        else $error("bad pc jump");
    a_pc_branch: assert property (
        cpu_run && pc_op == CRF_PC_BRANCH |=> program_counter == $past(program_counter)
        + {{8{$past(branch_off[7])}}, $past(branch_off)}) else $error("bad pc branch");
    a_sp_adjust: assert property (
        cpu_run && sp_op == CRF_SP_ADJ |=> stack_pointer == $past(stack_pointer)
        + {{8{$past(stack_adjust_immediate[7])}}, $past(stack_adjust_immediate)})
        else $error("bad stack adjust");
    a_sp_lowrst: assert property (
        cpu_run && sp_op == CRF_SP_LOWRST |=> stack_pointer[7:0] == 8'hff
        && $stable(stack_pointer[15:8])) else $error("bad stack low reset");
    a_hx_high_kept: assert property (
        cpu_run && hx_op inside {CRF_HX_LOAD_LOW, CRF_HX_INC_LOW, CRF_HX_DEC_LOW}
        |=> $stable(index_pair[15:8])) else $error("index high byte changed");
    a_flags_ones: assert property (
        condition_flags[6:5] == 2'b11) else $error("flag ones lost");
    a_irq_mask: assert property (
        cpu_run && irq_stacked |=> condition_flags[3]) else $error("mask not set");
endmodule : crf_regfile_assertions

bind crf_regfile crf_regfile_assertions chk_u (.*);

`default_nettype wire

// [core/crf_addr_calc.sv]
// Address arithmetic for branches, stack adjust, direct and indexed modes.
`timescale 1ns/1ps
`default_nettype none

`include "crf_defs.svh"

module crf_addr_calc
    import crf_pkg::*;
(
    crf_addr_if.calc io
);

    // =============================================================
    // Sign extension of the 8-bit offsets
    wire [15:0] branch_sext = {{8{io.branch_off[7]}}, io.branch_off};
    wire [15:0] imm_sext    = {{8{io.stack_imm[7]}}, io.stack_imm};

    // =============================================================
    // Sums kept to 16 bits so every pointer wraps modulo 65536
    assign io.branch_target  = 16'(io.program_counter + branch_sext);
    assign io.stack_adjusted = 16'(io.stack_pointer + imm_sext);
    assign io.direct_addr    = {`CRF_ZERO_PAGE, io.direct_off};
    assign io.indexed_addr   = 16'(io.index_pair + io.index_off);

endmodule : crf_addr_calc

`default_nettype wire

// [core/crf_addr_if.sv]
// Interface between the register file and its address calculator.
`timescale 1ns/1ps
`default_nettype none

interface crf_addr_if;
    logic [15:0] program_counter;
    logic [15:0] stack_pointer;
    logic [15:0] index_pair;
    logic [7:0]  branch_off;
    logic [7:0]  stack_imm;
    logic [7:0]  direct_off;
    logic [15:0] index_off;
    logic [15:0] branch_target;
    logic [15:0] stack_adjusted;
    logic [15:0] direct_addr;
    logic [15:0] indexed_addr;

    // Calculator side
    modport calc (
        input  program_counter, stack_pointer, index_pair,
        input  branch_off, stack_imm, direct_off, index_off,
        output branch_target, stack_adjusted, direct_addr, indexed_addr
    );

    // Register file side
    modport regs (
        output program_counter, stack_pointer, index_pair,
        output branch_off, stack_imm, direct_off, index_off,
        input  branch_target, stack_adjusted, direct_addr, indexed_addr
    );
endinterface : crf_addr_if

`default_nettype wire

// [core/crf_defs.svh]
// Constants for the CPU register file: reset values, vector addresses, flag positions.
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

// =============================================================
// Reset values
`define CRF_H_RST        8'h00
`define CRF_SP_RST       16'h00ff
`define CRF_PC_RST       16'h0000
`define CRF_FLAGS_RST    8'h08

// =============================================================
// Reset vector locations, high byte first
`define CRF_VEC_HI_ADDR  16'hfffe
`define CRF_VEC_LO_ADDR  16'hffff

// =============================================================
// Condition flag layout, stack low reset byte and zero page
`define CRF_FLAGS_ONES   8'h60
`define CRF_I_BIT        3
`define CRF_SP_LOW_RST   8'hff
`define CRF_ZERO_PAGE    8'h00
`endif

// [core/crf_pkg.sv]
// Types shared by the CPU register file and its address calculator.
`default_nettype none
package crf_pkg;
    // =============================================================
    // Program counter operations
    typedef enum logic [1:0] {
        CRF_PC_HOLD   = 2'h0,
        CRF_PC_INC    = 2'h1,
        CRF_PC_JUMP   = 2'h2,
        CRF_PC_BRANCH = 2'h3
    } crf_pc_op_t;

    // =============================================================
    // Stack pointer operations
    typedef enum logic [2:0] {
        CRF_SP_HOLD   = 3'h0,
        CRF_SP_PUSH   = 3'h1,
        CRF_SP_PULL   = 3'h2,
        CRF_SP_ADJ    = 3'h3,
        CRF_SP_LOWRST = 3'h4,
        CRF_SP_LOAD   = 3'h5
    } crf_sp_op_t;

    // =============================================================
    // Index pair operations
    typedef enum logic [2:0] {
        CRF_HX_HOLD     = 3'h0,
        CRF_HX_LOAD_LOW = 3'h1,
        CRF_HX_LOAD_HI  = 3'h2,
        CRF_HX_LOAD     = 3'h3,
        CRF_HX_INC      = 3'h4,
        CRF_HX_INC_LOW  = 3'h5,
        CRF_HX_DEC_LOW  = 3'h6
    } crf_hx_op_t;

    // =============================================================
    // Memory address source
    typedef enum logic [2:0] {
        CRF_AS_PC     = 3'h0,
        CRF_AS_INDEX  = 3'h1,
        CRF_AS_STACK  = 3'h2,
        CRF_AS_DIRECT = 3'h3,
        CRF_AS_EXT    = 3'h4
    } crf_addr_sel_t;

    // =============================================================
    // Reset vector fetch sequence, Gray coded
    typedef enum logic [1:0] {
        CRF_ST_VEC_HI = 2'b00,
        CRF_ST_VEC_LO = 2'b01,
        CRF_ST_RUN    = 2'b11
    } crf_state_t;

endpackage : crf_pkg
`default_nettype wire

// [core/crf_regfile.sv]
// Programmer-visible register set of the 8-bit CPU core.
//
// Function
// - Accumulator is 8 bits, feeds arithmetic operand, unchanged by reset.
// - Index pair is high and low byte; indexed addressing uses all 16 bits.
// - Some instructions touch only the low index byte, leaving high byte alone.
// - Reset clears the high index byte to zero.
// - Reset leaves the low index byte unchanged.
// - Stack pointer is 16 bits and addresses the next free stack location.
// - Calls push the return address; interrupts also push the CPU registers.
// - Reset loads the stack pointer with 0x00FF.
// - Stack adjust adds a sign-extended 8-bit immediate to the stack pointer.
// - Stack low reset changes only the low stack pointer byte.
// - Program counter is 16 bits, addressing the next fetch.
// - Program counter advances by one after each instruction or operand fetch.
// - Jumps, branches, interrupts and returns load a non-sequential target.
// - Leaving reset, fetch the vector at top of memory, start there.
// - CPU registers are unmapped; one 64-Kbyte space of 16-bit addresses.
// - Direct addressing reaches only the lowest 256 locations.
// - Relative addressing applies a signed 8-bit offset to the program counter.
// - Condition flag bits 6 and 5 always read as ones.
// - Interrupt mask sets after registers are stacked, before service begins.
// - Branch offset sign-extends to 16 bits and adds to program counter.
`timescale 1ns/1ps
`default_nettype none

`include "crf_defs.svh"

module crf_regfile
    import crf_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // Program counter control
    input  wire crf_pc_op_t    pc_op,
    input  wire logic [15:0]   pc_load_addr,
    input  wire logic [7:0]    branch_off,
    // Stack pointer control
    input  wire crf_sp_op_t    sp_op,
    input  wire logic [7:0]    stack_adjust_immediate,
    input  wire logic [15:0]   sp_load_val,
    // Index pair control
    input  wire crf_hx_op_t    hx_op,
    input  wire logic [15:0]   hx_wdata,
    // Accumulator and flags
    input  wire logic          acc_we,
    input  wire logic [7:0]    acc_wdata,
    input  wire logic          flags_we,
    input  wire logic [7:0]    flags_wdata,
    input  wire logic          irq_stacked,
    // Address selection
    input  wire crf_addr_sel_t addr_sel,
    input  wire logic [7:0]    direct_off,
    input  wire logic [15:0]   index_off,
    input  wire logic [15:0]   ext_addr,
    // Memory read data for the vector fetch
    input  wire logic [7:0]    mem_rdata,
    input  wire logic          mem_rvalid,
    // Outputs
    output logic [15:0]        mem_addr,
    output logic               vec_rd,
    output logic               cpu_run,
    output logic [15:0]        branch_target,
    output logic [15:0]        indexed_addr,
    output logic [7:0]         accumulator,
    output logic [7:0]         arith_operand_a,
    output logic [15:0]        index_pair,
    output logic [15:0]        stack_pointer,
    output logic [15:0]        program_counter,
    output logic [7:0]         condition_flags
);

    // =============================================================
    // State and registers
    crf_state_t  state_q;
    crf_state_t  state_d;
    logic [7:0]  acc_q;
    logic [7:0]  acc_d;
    logic [7:0]  idx_hi_q;
    logic [7:0]  idx_hi_d;
    logic [7:0]  idx_lo_q;
    logic [7:0]  idx_lo_d;
    logic [15:0] sp_q;
    logic [15:0] sp_d;
    logic [15:0] pc_q;
    logic [15:0] pc_d;
    logic [7:0]  flags_q;
    logic [7:0]  flags_d;

    crf_addr_if addr_io ();

    // =============================================================
    // Address calculator hookup
    assign addr_io.program_counter = pc_q;
    assign addr_io.stack_pointer   = sp_q;
    assign addr_io.index_pair      = {idx_hi_q, idx_lo_q};
    assign addr_io.branch_off      = branch_off;
    assign addr_io.stack_imm       = stack_adjust_immediate;
    assign addr_io.direct_off      = direct_off;
    assign addr_io.index_off       = index_off;

    crf_addr_calc u_calc (
        .io (addr_io.calc)
    );

    // =============================================================
    // Decodes
    wire running   = (state_q == CRF_ST_RUN);
    wire fetch_hi  = (state_q == CRF_ST_VEC_HI) && mem_rvalid;
    wire fetch_lo  = (state_q == CRF_ST_VEC_LO) && mem_rvalid;
    wire [15:0] hx = {idx_hi_q, idx_lo_q};
    wire [15:0] hx_inc = 16'(hx + 16'h0001);
    wire [15:0] pc_inc = 16'(pc_q + 16'h0001);
    wire [15:0] sp_dec = 16'(sp_q - 16'h0001);
    wire [15:0] sp_inc = 16'(sp_q + 16'h0001);

    // =============================================================
    // Vector fetch sequencer: high byte then low byte, then run
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CRF_ST_VEC_HI: begin
                if (mem_rvalid) begin
                    state_d = CRF_ST_VEC_LO;
                end
            end
            CRF_ST_VEC_LO: begin
                if (mem_rvalid) begin
                    state_d = CRF_ST_RUN;
                end
            end
            CRF_ST_RUN: begin
                state_d = CRF_ST_RUN;
            end
            default: begin
                state_d = CRF_ST_VEC_HI;                     // Illegal code recovers
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= CRF_ST_VEC_HI;
        end else begin
            state_q <= state_d;
        end
    end

    // =============================================================
    // Accumulator: no reset term at all, so its contents survive reset
    assign acc_d = (running && acc_we) ? acc_wdata : acc_q;

    always_ff @(posedge ref_clk) begin
        acc_q <= acc_d;
    end

    // =============================================================
    // Index pair; low-byte operations leave the high byte alone
    always_comb begin
        idx_hi_d = idx_hi_q;
        idx_lo_d = idx_lo_q;
        if (running) begin
            unique case (hx_op)
                CRF_HX_HOLD: begin
                    idx_hi_d = idx_hi_q;
                end
                CRF_HX_LOAD_LOW: begin
                    idx_lo_d = hx_wdata[7:0];
                end
                CRF_HX_LOAD_HI: begin
                    idx_hi_d = hx_wdata[15:8];
                end
                CRF_HX_LOAD: begin
                    idx_hi_d = hx_wdata[15:8];
                    idx_lo_d = hx_wdata[7:0];
                end
                CRF_HX_INC: begin
                    idx_hi_d = hx_inc[15:8];
                    idx_lo_d = hx_inc[7:0];
                end
                CRF_HX_INC_LOW: begin
                    idx_lo_d = 8'(idx_lo_q + 8'h01);
                end
                CRF_HX_DEC_LOW: begin
                    idx_lo_d = 8'(idx_lo_q - 8'h01);
                end
                default: begin
                    idx_hi_d = idx_hi_q;                     // Unused code holds
                end
            endcase
        end
    end

    // High byte clears on reset; low byte has no reset path
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            idx_hi_q <= `CRF_H_RST;
        end else begin
            idx_hi_q <= idx_hi_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        idx_lo_q <= (!rst_n) ? idx_lo_q : idx_lo_d;
    end

    // =============================================================
    // Stack pointer: points at next free slot, so push decrements after write
    always_comb begin
        sp_d = sp_q;
        if (running) begin
            unique case (sp_op)
                CRF_SP_HOLD: begin
                    sp_d = sp_q;
                end
                CRF_SP_PUSH: begin
                    sp_d = sp_dec;
                end
                CRF_SP_PULL: begin
                    sp_d = sp_inc;
                end
                CRF_SP_ADJ: begin
                    sp_d = addr_io.stack_adjusted;
                end
                CRF_SP_LOWRST: begin
                    sp_d = {sp_q[15:8], `CRF_SP_LOW_RST};
                end
                CRF_SP_LOAD: begin
                    sp_d = sp_load_val;
                end
                default: begin
                    sp_d = sp_q;                             // Unused codes hold
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sp_q <= `CRF_SP_RST;
        end else begin
            sp_q <= sp_d;
        end
    end

    // =============================================================
    // Program counter: vector load first, then sequential or change of flow
    always_comb begin
        pc_d = pc_q;
        if (fetch_hi) begin
            pc_d = {mem_rdata, pc_q[7:0]};
        end else if (fetch_lo) begin
            pc_d = {pc_q[15:8], mem_rdata};
        end else if (running) begin
            unique case (pc_op)
                CRF_PC_HOLD: begin
                    pc_d = pc_q;
                end
                CRF_PC_INC: begin
                    pc_d = pc_inc;
                end
                CRF_PC_JUMP: begin
                    pc_d = pc_load_addr;
                end
                CRF_PC_BRANCH: begin
                    pc_d = addr_io.branch_target;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pc_q <= `CRF_PC_RST;
        end else begin
            pc_q <= pc_d;
        end
    end

    // =============================================================
    // Condition flags; the stacked event sets the mask and wins over a write
    always_comb begin
        flags_d = flags_q;
        if (running && flags_we) begin
            flags_d = flags_wdata;
        end
        if (running && irq_stacked) begin
            flags_d[`CRF_I_BIT] = 1'b1;
        end
        flags_d = flags_d | `CRF_FLAGS_ONES;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flags_q <= `CRF_FLAGS_RST | `CRF_FLAGS_ONES;
        end else begin
            flags_q <= flags_d;
        end
    end

    // =============================================================
    // Memory address select; registers themselves are never mapped as locations
    always_comb begin
        mem_addr = pc_q;
        unique case (state_q)
            CRF_ST_VEC_HI: begin
                mem_addr = `CRF_VEC_HI_ADDR;
            end
            CRF_ST_VEC_LO: begin
                mem_addr = `CRF_VEC_LO_ADDR;
            end
            CRF_ST_RUN: begin
                unique case (addr_sel)
                    CRF_AS_PC: begin
                        mem_addr = pc_q;
                    end
                    CRF_AS_INDEX: begin
                        mem_addr = addr_io.indexed_addr;
                    end
                    CRF_AS_STACK: begin
                        mem_addr = sp_q;
                    end
                    CRF_AS_DIRECT: begin
                        mem_addr = addr_io.direct_addr;
                    end
                    CRF_AS_EXT: begin
                        mem_addr = ext_addr;
                    end
                    default: begin
                        mem_addr = pc_q;
                    end
                endcase
            end
            default: begin
                mem_addr = `CRF_VEC_HI_ADDR;
            end
        endcase
    end

    // =============================================================
    // Outputs
    assign vec_rd          = !running;
    assign cpu_run         = running;
    assign branch_target   = addr_io.branch_target;
    assign indexed_addr    = addr_io.indexed_addr;
    assign accumulator     = acc_q;
    assign arith_operand_a = acc_q;
    assign index_pair      = hx;
    assign stack_pointer   = sp_q;
    assign program_counter = pc_q;
    assign condition_flags = flags_q | `CRF_FLAGS_ONES;

endmodule : crf_regfile

`default_nettype wire
